// file: hdl/sdma_pkg.sv
package sdma_pkg;
   localparam int NUM_CH = 6;
   localparam int ST_W = 16;
   // structure word layout
   localparam int ST_MODE_LSB = 14;
   localparam int ST_RPOW_LSB = 10;
   localparam int ST_CNT_LSB = 0;
   localparam int ST_CNT_W = 10;
   localparam logic [1:0] MODE_INVALID = 2'h0;
   localparam logic [1:0] MODE_BASIC = 2'h1;
   localparam logic [1:0] MODE_AUTO = 2'h2;
   localparam logic [1:0] MODE_PINGPONG = 2'h3;
   localparam logic [ST_W-1:0] ST_RESET = 16'h0000;
   // apb register offsets
   localparam logic [7:0] REG_CHAN_EN = 8'h00;
   localparam logic [7:0] REG_PRIO = 8'h04;
   localparam logic [7:0] REG_SWREQ = 8'h08;
   localparam logic [7:0] REG_STRUCT = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_IRQ_CLR = 8'h14;
   localparam logic [7:0] REG_IRQ_EN = 8'h18;
   localparam int STRUCT_IDX_LSB = 16;
   localparam logic [NUM_CH-1:0] CH_RESET = 6'h00;

   typedef enum logic [3:0] {
      ST_ARB = 4'h1,
      ST_LOAD = 4'h2,
      ST_XFER = 4'h4,
      ST_FIN = 4'h8
   } sdma_state_t;

   // structure slot: channel index then primary(0)/alternate(1)
   function automatic logic [3:0] st_slot(input logic [2:0] ch, input logic alt);
      st_slot = {ch, alt};
   endfunction : st_slot
endpackage : sdma_pkg

// file: hdl/sdma_if.sv
interface sdma_if;
   logic [5:0] chan_en;
   logic [5:0] pri_high;
   logic [5:0] sw_req;
   logic st_we;
   logic [3:0] st_slot;
   logic [15:0] st_wdata;
   logic [5:0] done;

   modport dev (
      input chan_en, pri_high, sw_req, st_we, st_slot, st_wdata,
      output done
   );
   modport host (
      output chan_en, pri_high, sw_req, st_we, st_slot, st_wdata,
      input done
   );
endinterface : sdma_if

// file: hdl/sdma_arb.sv
module sdma_arb (
   // pending and priority
   input wire logic [5:0] req_i,
   input wire logic [5:0] high_i,
   // grant
   output logic vld_o,
   output logic [2:0] idx_o
);
   function automatic logic [2:0] first_set(input logic [5:0] v);
      first_set = 3'h0;
      for (int i = 5; i >= 0; i--) begin
         if (v[i]) begin
            first_set = 3'(i);
         end
      end
   endfunction : first_set

   always_comb begin
      vld_o = |req_i;
      if (|(req_i & high_i)) begin
         idx_o = first_set(req_i & high_i);
      end else begin
         idx_o = first_set(req_i);
      end
   end
endmodule : sdma_arb

// file: hdl/sdma_ctrl.sv
// Added by the designer: the APB slave port and the register offsets.
module sdma_ctrl (
   // system
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // peripheral requests
   input wire logic sync_serial0_tx_req_i,
   input wire logic sync_serial0_rx_req_i,
   input wire logic sync_serial1_tx_req_i,
   input wire logic sync_serial1_rx_req_i,
   input wire logic async_serial0_tx_req_i,
   input wire logic async_serial0_rx_req_i,
   input wire logic async_serial1_tx_req_i,
   input wire logic async_serial1_rx_req_i,
   // memory beat port
   output logic mem_req_o,
   output logic [2:0] mem_ch_o,
   output logic mem_alt_o,
   input wire logic mem_ready_i,
   // host side
   sdma_if.dev host_if
);
   // one word per channel and structure, indexed by {channel, alternate}
   logic [15:0] st_mem [16];
   logic [5:0] hw_req;
   logic [5:0] pend_ff;
   logic [5:0] alt_ff;
   logic [5:0] done_ff;
   logic [5:0] clr_pend;
   logic [5:0] flip_alt;
   sdma_pkg::sdma_state_t state_ff;
   logic [2:0] ch_ff;
   logic alt_cur_ff;
   logic [1:0] mode_ff;
   logic [9:0] rem_ff;
   logic [15:0] grp_ff;
   logic mem_req_ff;
   logic gnt_vld;
   logic [2:0] gnt_idx;
   logic [15:0] rd_word;
   logic beat;
   logic st_fsm_we;
   logic [3:0] st_fsm_slot;
   logic [15:0] st_fsm_data;

   // channels four and five have no hardware source
   // tx and rx of one port share a channel; the two requests are ORed into one
   assign hw_req = {2'h0,
                    async_serial1_tx_req_i | async_serial1_rx_req_i,
                    async_serial0_tx_req_i | async_serial0_rx_req_i,
                    sync_serial1_tx_req_i | sync_serial1_rx_req_i,
                    sync_serial0_tx_req_i | sync_serial0_rx_req_i};

   assign rd_word = st_mem[sdma_pkg::st_slot(ch_ff, alt_cur_ff)];
   assign beat = mem_req_ff & mem_ready_i;

   // a disabled channel stays out of arbitration but keeps its request pending
   sdma_arb sdma_arb_i (
      .req_i(pend_ff & host_if.chan_en),
      .high_i(host_if.pri_high),
      .vld_o(gnt_vld),
      .idx_o(gnt_idx)
   );

   // request capture: a new request beats a same-cycle clear
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         pend_ff <= sdma_pkg::CH_RESET;
      end else begin
         pend_ff <= (pend_ff & ~clr_pend) | hw_req | host_if.sw_req;
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         alt_ff <= sdma_pkg::CH_RESET;
      end else begin
         alt_ff <= alt_ff ^ flip_alt;
      end
   end

   // decisions of the sequencer that touch per-channel state
   always_comb begin
      clr_pend = 6'h00;
      flip_alt = 6'h00;
      st_fsm_we = 1'b0;
      st_fsm_slot = sdma_pkg::st_slot(ch_ff, alt_cur_ff);
      st_fsm_data = rd_word;
      case (state_ff)
         sdma_pkg::ST_LOAD: begin
            if (rd_word[sdma_pkg::ST_MODE_LSB +: 2] == sdma_pkg::MODE_INVALID ||
                !host_if.chan_en[ch_ff]) begin
               clr_pend[ch_ff] = 1'b1;
            end else if (rd_word[sdma_pkg::ST_MODE_LSB +: 2] == sdma_pkg::MODE_BASIC) begin
               // basic needs a fresh request for every group
               clr_pend[ch_ff] = 1'b1;
            end
         end
         sdma_pkg::ST_XFER: begin
            if (beat && rem_ff != 10'h000 && grp_ff == 16'h0000) begin
               // park remaining count so the cycle resumes after arbitration
               st_fsm_we = 1'b1;
               st_fsm_data[sdma_pkg::ST_CNT_LSB +: sdma_pkg::ST_CNT_W] = rem_ff - 10'h001;
            end
         end
         sdma_pkg::ST_FIN: begin
            st_fsm_we = 1'b1;
            st_fsm_data[sdma_pkg::ST_MODE_LSB +: 2] = sdma_pkg::MODE_INVALID;
            if (mode_ff == sdma_pkg::MODE_PINGPONG && host_if.chan_en[ch_ff]) begin
               // request stays pending so the other structure is loaded next
               flip_alt[ch_ff] = 1'b1;
            end else begin
               clr_pend[ch_ff] = 1'b1;
            end
         end
         default: begin
         end
      endcase
   end

   // structure store; a host write to the same slot lands last
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < 16; i++) begin
            st_mem[i] <= sdma_pkg::ST_RESET;
         end
      end else begin
         if (st_fsm_we) begin
            st_mem[st_fsm_slot] <= st_fsm_data;
         end
         if (host_if.st_we) begin
            st_mem[host_if.st_slot] <= host_if.st_wdata;
         end
      end
   end

   // sequencer: one channel at a time, back to arbitration after every group
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         state_ff <= sdma_pkg::ST_ARB;
         ch_ff <= 3'h0;
         alt_cur_ff <= 1'b0;
         mode_ff <= sdma_pkg::MODE_INVALID;
         rem_ff <= 10'h000;
         grp_ff <= 16'h0000;
         mem_req_ff <= 1'b0;
      end else begin
         case (state_ff)
            sdma_pkg::ST_ARB: begin
               if (gnt_vld) begin
                  ch_ff <= gnt_idx;
                  alt_cur_ff <= alt_ff[gnt_idx];
                  state_ff <= sdma_pkg::ST_LOAD;
               end
            end
            sdma_pkg::ST_LOAD: begin
               if (rd_word[sdma_pkg::ST_MODE_LSB +: 2] == sdma_pkg::MODE_INVALID ||
                   !host_if.chan_en[ch_ff]) begin
                  state_ff <= sdma_pkg::ST_ARB;
               end else begin
                  mode_ff <= rd_word[sdma_pkg::ST_MODE_LSB +: 2];
                  rem_ff <= rd_word[sdma_pkg::ST_CNT_LSB +: sdma_pkg::ST_CNT_W];
                  grp_ff <= (16'h0001 << rd_word[sdma_pkg::ST_RPOW_LSB +: 4]) - 16'h0001;
                  mem_req_ff <= 1'b1;
                  state_ff <= sdma_pkg::ST_XFER;
               end
            end
            sdma_pkg::ST_XFER: begin
               if (beat) begin
                  if (rem_ff == 10'h000) begin
                     mem_req_ff <= 1'b0;
                     state_ff <= sdma_pkg::ST_FIN;
                  end else if (grp_ff == 16'h0000) begin
                     // group over: auto and ping-pong keep their request, basic waits
                     mem_req_ff <= 1'b0;
                     state_ff <= sdma_pkg::ST_ARB;
                  end else begin
                     rem_ff <= rem_ff - 10'h001;
                     grp_ff <= grp_ff - 16'h0001;
                  end
               end
            end
            sdma_pkg::ST_FIN: begin
               state_ff <= sdma_pkg::ST_ARB;
            end
            default: begin
               state_ff <= sdma_pkg::ST_ARB;
            end
         endcase
      end
   end

   // done follows the finish state, when the invalid writeback has landed
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         done_ff <= 6'h00;
      end else begin
         done_ff <= 6'h00;
         if (state_ff == sdma_pkg::ST_FIN) begin
            done_ff[ch_ff] <= 1'b1;
         end
      end
   end

   assign mem_req_o = mem_req_ff;
   assign mem_ch_o = ch_ff;
   assign mem_alt_o = alt_cur_ff;
   assign host_if.done = done_ff;
endmodule : sdma_ctrl

// file: hdl/sdma_host.sv
module sdma_host (
   // system
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // interrupt
   output logic irq_o,
   // controller side
   sdma_if.host dma_if
);
   logic [5:0] en_ff;
   logic [5:0] pri_ff;
   logic [5:0] swreq_ff;
   logic st_we_ff;
   logic [3:0] st_slot_ff;
   logic [15:0] st_data_ff;
   logic [5:0] status_ff;
   logic [5:0] irq_en_ff;
   logic [5:0] clr;
   logic irq_ff;
   logic [31:0] prdata_ff;
   logic pslverr_ff;
   logic pready_ff;
   logic setup;
   logic wr;

   assign setup = psel & ~penable;
   // zero-wait slave: the access phase always completes on its first edge
   assign wr = psel & penable & pwrite;

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         en_ff <= sdma_pkg::CH_RESET;
         pri_ff <= sdma_pkg::CH_RESET;
         irq_en_ff <= sdma_pkg::CH_RESET;
      end else if (wr) begin
         if (paddr == sdma_pkg::REG_CHAN_EN) begin
            en_ff <= pwdata[5:0];
         end else if (paddr == sdma_pkg::REG_PRIO) begin
            pri_ff <= pwdata[5:0];
         end else if (paddr == sdma_pkg::REG_IRQ_EN) begin
            irq_en_ff <= pwdata[5:0];
         end
      end
   end

   // software request and structure write are one-cycle strobes
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         swreq_ff <= 6'h00;
         st_we_ff <= 1'b0;
         st_slot_ff <= 4'h0;
         st_data_ff <= sdma_pkg::ST_RESET;
      end else begin
         swreq_ff <= (wr && paddr == sdma_pkg::REG_SWREQ) ? pwdata[5:0] : 6'h00;
         st_we_ff <= wr && paddr == sdma_pkg::REG_STRUCT;
         if (wr && paddr == sdma_pkg::REG_STRUCT) begin
            st_slot_ff <= pwdata[sdma_pkg::STRUCT_IDX_LSB +: 4];
            st_data_ff <= pwdata[15:0];
         end
      end
   end

   // done capture wins over a same-cycle clear
   assign clr = (wr && paddr == sdma_pkg::REG_IRQ_CLR) ? pwdata[5:0] : 6'h00;

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         status_ff <= 6'h00;
         irq_ff <= 1'b0;
      end else begin
         status_ff <= (status_ff & ~clr) | dma_if.done;
         irq_ff <= |(((status_ff & ~clr) | dma_if.done) & irq_en_ff);
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         prdata_ff <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
         pready_ff <= 1'b0;
      end else begin
         pready_ff <= 1'b1;
         if (setup) begin
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            if (paddr == sdma_pkg::REG_CHAN_EN) begin
               prdata_ff <= {26'h0, en_ff};
            end else if (paddr == sdma_pkg::REG_PRIO) begin
               prdata_ff <= {26'h0, pri_ff};
            end else if (paddr == sdma_pkg::REG_STATUS) begin
               prdata_ff <= {26'h0, status_ff};
            end else if (paddr == sdma_pkg::REG_IRQ_EN) begin
               prdata_ff <= {26'h0, irq_en_ff};
            end else if (paddr != sdma_pkg::REG_SWREQ && paddr != sdma_pkg::REG_STRUCT &&
                         paddr != sdma_pkg::REG_IRQ_CLR) begin
               pslverr_ff <= 1'b1;
            end
         end
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign irq_o = irq_ff;
   assign dma_if.chan_en = en_ff;
   assign dma_if.pri_high = pri_ff;
   assign dma_if.sw_req = swreq_ff;
   assign dma_if.st_we = st_we_ff;
   assign dma_if.st_slot = st_slot_ff;
   assign dma_if.st_wdata = st_data_ff;
endmodule : sdma_host

// file: sim/sdma_monitor.sv
module sdma_monitor (
   // system
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // link and memory port
   input wire logic [5:0] chan_en_i,
   input wire logic [5:0] done_i,
   input wire logic mem_req_i,
   input wire logic [2:0] mem_ch_i,
   input wire logic mem_ready_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic beat;
   assign beat = mem_req_i && mem_ready_i;
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (sys_rst_i);
   a_done_one_cycle: assert property ((done_i & $past(done_i)) == 6'h00)
      else $error("done held too long");
   a_done_single: assert property ($onehot0(done_i))
      else $error("two done pulses at once");
   a_done_after_beat: assert property (done_i != 6'h00 |->
      $past(beat, 1) || $past(beat, 2) || $past(beat, 3))
      else $error("done without a final beat");
   a_beat_held: assert property (mem_req_i && !mem_ready_i |=> mem_req_i && $stable(mem_ch_i))
      else $error("offered beat withdrawn");
   a_fall_on_beat: assert property ($fell(mem_req_i) |-> $past(mem_ready_i))
      else $error("group ended without beat");
   a_gap_after_group: assert property ($fell(mem_req_i) |=> !mem_req_i)
      else $error("no arbitration between groups");
   a_ch_range: assert property (mem_req_i |-> mem_ch_i <= 3'h5)
      else $error("channel out of range");
   a_ch_enabled: assert property ($rose(mem_req_i) |-> chan_en_i[mem_ch_i])
      else $error("disabled channel served");
   c_done_pp: cover property (done_i[1]);
   c_group_end: cover property ($fell(mem_req_i));
   c_last_ch: cover property (mem_req_i && mem_ch_i == 3'h5);
endmodule : sdma_monitor

// file: sim/sdma_bench.sv
module sdma_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i, sys_rst_i, psel, penable, pwrite, pready, pslverr, irq_o;
   logic [7:0] paddr, hw_req;
   logic [31:0] pwdata, prdata;
   logic mem_req_o, mem_alt_o, mem_ready_i;
   logic [2:0] mem_ch_o;
   logic [3:0] beat_q[$];
   logic [5:0] done_q[$];
   logic [3:0] exp_beat;
   int err_total, compares, cyc;
   sdma_if bus ();
   sdma_ctrl sdma_ctrl_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
      .sync_serial0_tx_req_i(hw_req[0]), .sync_serial0_rx_req_i(hw_req[1]),
      .sync_serial1_tx_req_i(hw_req[2]), .sync_serial1_rx_req_i(hw_req[3]),
      .async_serial0_tx_req_i(hw_req[4]), .async_serial0_rx_req_i(hw_req[5]),
      .async_serial1_tx_req_i(hw_req[6]), .async_serial1_rx_req_i(hw_req[7]),
      .mem_req_o(mem_req_o), .mem_ch_o(mem_ch_o), .mem_alt_o(mem_alt_o),
      .mem_ready_i(mem_ready_i), .host_if(bus));
   sdma_host sdma_host_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq_o(irq_o), .dma_if(bus));
   sdma_monitor sdma_monitor_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
      .chan_en_i(bus.chan_en), .done_i(bus.done), .mem_req_i(mem_req_o), .mem_ch_i(mem_ch_o),
      .mem_ready_i(mem_ready_i));
   initial begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end
   task automatic conclude;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : conclude
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic er);
      @(posedge clock_i);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      do @(posedge clock_i); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(nm, x, r);
      chk("pslverr", 32'(xe), 32'(e));
   endtask : rdc
   task automatic st(input int ch, input int alt, input logic [1:0] m, input int r, input int n);
      wr(sdma_pkg::REG_STRUCT, 32'((ch * 2 + alt) << sdma_pkg::STRUCT_IDX_LSB)
         | (32'(m) << sdma_pkg::ST_MODE_LSB) | 32'(r << sdma_pkg::ST_RPOW_LSB) | 32'(n - 1));
   endtask : st
   task automatic expect_beats(input int ch, input int alt, input int cnt);
      repeat (cnt) beat_q.push_back(4'(ch * 2 + alt));
   endtask : expect_beats
   // the quiet tail catches beats or done pulses that nobody expected
   task automatic drain;
      while (beat_q.size() + done_q.size() != 0) @(posedge clock_i);
      repeat (24) @(posedge clock_i);
   endtask : drain
   task automatic hw(input int k);
      @(posedge clock_i);
      hw_req <= 8'h01 << k;
      @(posedge clock_i);
      hw_req <= 8'h00;
   endtask : hw
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (!sys_rst_i && mem_req_o && mem_ready_i) begin
         exp_beat = beat_q.size() ? beat_q.pop_front() : 4'hf;
         chk("beat", exp_beat, {mem_ch_o, mem_alt_o});
      end
      if (!sys_rst_i && bus.done !== 6'h00)
         chk("done", done_q.size() ? done_q.pop_front() : 6'h00, bus.done);
      if (cyc == 20000) begin
         err_total++;
         $display("ERROR timeout expected below %0d cycles seen %0d", 20000, cyc);
         conclude();
      end
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, hw_req, mem_ready_i} = '0;
      sys_rst_i = 1'b1;
      {err_total, compares, cyc} = '0;
      void'($urandom(32'h1c733c3b));
      // forked after seeding so the ready pattern follows the seed
      fork
         forever begin
            @(posedge clock_i);
            mem_ready_i <= ($urandom % 4) != 0;
         end
      join_none
      repeat (3) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      rdc("chan_en", sdma_pkg::REG_CHAN_EN, 32'h0, 1'b0);
      rdc("unmapped", 8'h1c, 32'h0, 1'b1);
      wr(sdma_pkg::REG_CHAN_EN, 32'h3f);
      for (int k = 0; k < 8; k++) begin
         st(k / 2, 0, sdma_pkg::MODE_BASIC, 0, 1);
         expect_beats(k / 2, 0, 1);
         done_q.push_back(6'h01 << (k / 2));
         hw(k);
         drain();
      end
      // three beats in groups of two: one group per request, leftover last
      st(0, 0, sdma_pkg::MODE_BASIC, 1, 3);
      expect_beats(0, 0, 2);
      hw(1);
      drain();
      expect_beats(0, 0, 1);
      done_q.push_back(6'h01);
      hw(0);
      drain();
      hw(0);
      drain();
      // a request on a disabled channel waits until the channel is enabled
      wr(sdma_pkg::REG_CHAN_EN, 32'h3e);
      rdc("chan_en", sdma_pkg::REG_CHAN_EN, 32'h3e, 1'b0);
      st(0, 0, sdma_pkg::MODE_BASIC, 0, 1);
      hw(0);
      drain();
      expect_beats(0, 0, 1);
      done_q.push_back(6'h01);
      wr(sdma_pkg::REG_CHAN_EN, 32'h3f);
      drain();
      st(4, 0, sdma_pkg::MODE_AUTO, 2, 6);
      expect_beats(4, 0, 6);
      done_q.push_back(6'h10);
      wr(sdma_pkg::REG_SWREQ, 32'h10);
      drain();
      for (int p = 0; p < 2; p++) begin
         st(4, 0, sdma_pkg::MODE_BASIC, 0, 1);
         st(5, 0, sdma_pkg::MODE_BASIC, 0, 1);
         wr(sdma_pkg::REG_PRIO, p ? 32'h0 : 32'h20);
         expect_beats(p ? 4 : 5, 0, 1);
         expect_beats(p ? 5 : 4, 0, 1);
         done_q.push_back(p ? 6'h10 : 6'h20);
         done_q.push_back(p ? 6'h20 : 6'h10);
         wr(sdma_pkg::REG_SWREQ, 32'h30);
         drain();
      end
      st(1, 0, sdma_pkg::MODE_PINGPONG, 0, 2);
      expect_beats(1, 0, 2);
      expect_beats(1, 1, 1);
      done_q.push_back(6'h02);
      done_q.push_back(6'h02);
      wr(sdma_pkg::REG_SWREQ, 32'h02);
      // the alternate lands while the primary is still running
      st(1, 1, sdma_pkg::MODE_PINGPONG, 1, 1);
      drain();
      rdc("status", sdma_pkg::REG_STATUS, 32'h3f, 1'b0);
      chk("irq masked", 32'h0, 32'(irq_o));
      wr(sdma_pkg::REG_IRQ_EN, 32'h04);
      repeat (3) @(posedge clock_i);
      chk("irq raised", 32'h1, 32'(irq_o));
      wr(sdma_pkg::REG_IRQ_CLR, 32'h04);
      repeat (3) @(posedge clock_i);
      chk("irq cleared", 32'h0, 32'(irq_o));
      rdc("status", sdma_pkg::REG_STATUS, 32'h3b, 1'b0);
      conclude();
   end
endmodule : sdma_bench
